// ### rtl/scm_pkg.sv
// Purpose: shared constants and types for the status change monitor
// Assumes: one 125 MHz core clock, asynchronous active-high reset
// Notes:   word layout and command encoding are collected here
package scm_pkg;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int unsigned GEN_W     = 38;  // general status lines
  localparam int unsigned WORD_W    = 12;  // data bits per input word
  localparam int unsigned NUM_WORDS = 6;   // general words on channel one
  localparam int unsigned IDX_W     = 3;   // word number width
  localparam int unsigned PAD_W     = NUM_WORDS * WORD_W;
  localparam int unsigned NAV_W     = 10;  // navigation status bits
  localparam int unsigned BUF_W     = IDX_W + WORD_W;
  localparam int unsigned SYNC_W    = GEN_W + 1 + 1 + 1 + 1 + WORD_W;

  // ****************************************************************
  // output channel word fields
  // ****************************************************************
  localparam int unsigned CMD_BIT     = 11;  // 1 = store nav bits, 0 = request
  localparam int unsigned NAV_LSB     = 0;
  localparam int unsigned REQ_LSB     = 0;   // six word request bits
  localparam int unsigned REQ_SAD_BIT = 6;   // anomaly word request bit

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [NUM_WORDS-1:0] REQ_RST  = 6'h3f;  // send all six general words at start
  localparam logic [WORD_W-1:0]    WORD_RST = 12'h000;
  localparam logic [NAV_W-1:0]     NAV_RST  = 10'h000;

  // ****************************************************************
  // channel handshake states
  // ****************************************************************
  typedef enum logic [1:0]
  {
    SCM_IDLE    = 2'b00,
    SCM_ENTER   = 2'b01,
    SCM_RELEASE = 2'b10
  } scm_hs_t;

endpackage

// ### rtl/scm_buf_if.sv
// Purpose: valid/ready carrier between scanner, buffer and channel stage
// Assumes: one clock domain
// Notes:   data holds word number above word data
`timescale 1ns/1ps
`default_nettype none
interface scm_buf_if
  import scm_pkg::*;
();
  logic             valid;
  logic             ready;
  logic [BUF_W-1:0] data;

  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface
`default_nettype wire

// ### rtl/scm_buf.sv
// Purpose: two-entry word buffer with valid and ready on both sides
// Assumes: one clock domain
// Notes:   full drops ready so the scanner stalls and no word is lost
`timescale 1ns/1ps
`default_nettype none
module scm_buf
  import scm_pkg::*;
(
  // clock and reset
  input  wire logic   core_clk_i,
  input  wire logic   sys_rst_i,
  // filling and draining sides
  scm_buf_if.sink     in_if,
  scm_buf_if.source   out_if
);

  logic [BUF_W-1:0] mem_r [2];
  logic             wr_ptr_r;
  logic             rd_ptr_r;
  logic [1:0]       cnt_r;
  logic             push;
  logic             pop;

  // ****************************************************************
  // flags and strobes
  // ****************************************************************
  assign in_if.ready  = (cnt_r != 2'h2);
  assign out_if.valid = (cnt_r != 2'h0);
  assign out_if.data  = mem_r[rd_ptr_r];
  assign push         = in_if.valid && in_if.ready;
  assign pop          = out_if.valid && out_if.ready;

  // storage write
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      mem_r[0] <= '0;
      mem_r[1] <= '0;
    end
    else if (push)
    begin
      mem_r[wr_ptr_r] <= in_if.data;
    end
  end

  // pointers and fill count
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      cnt_r    <= 2'h0;
    end
    else
    begin
      if (push)
        wr_ptr_r <= ~wr_ptr_r;
      if (pop)
        rd_ptr_r <= ~rd_ptr_r;
      if (push && !pop)
        cnt_r <= cnt_r + 2'h1;
      else if (pop && !push)
        cnt_r <= cnt_r - 2'h1;
    end
  end

endmodule
`default_nettype wire

// ### rtl/scm_top.sv
// Purpose: status change monitor, sends changed or requested status words
// Assumes: all inputs are asynchronous pins; channels use four-phase enter/ack
// Notes:   extra lines fit by widening the general vector and word count
`timescale 1ns/1ps
`default_nettype none
module scm_top
  import scm_pkg::*;
(
  // clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              sys_rst_i,
  // monitored status lines
  input  wire logic [GEN_W-1:0]  gen_status_i,
  input  wire logic              anomaly_detector_status_i,
  // input_mux_channel one, general words
  output logic                   in_ch1_enter_o,
  output logic [WORD_W-1:0]      in_ch1_data_o,
  output logic [IDX_W-1:0]       in_ch1_word_o,
  input  wire logic              in_ch1_ack_i,
  // input_mux_channel two, anomaly word
  output logic                   in_ch2_enter_o,
  output logic [WORD_W-1:0]      in_ch2_data_o,
  input  wire logic              in_ch2_ack_i,
  // output_mux_channel
  input  wire logic              output_mux_channel_strobe_i,
  input  wire logic [WORD_W-1:0] output_mux_channel_data_i,
  output logic                   output_mux_channel_ack_o,
  // navigation system lines
  output logic [NAV_W-1:0]       nav_status_o
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [SYNC_W-1:0]    sync1_r;
  logic [SYNC_W-1:0]    sync2_r;
  logic [GEN_W-1:0]     gen_s;
  logic                 sad_s;
  logic                 ack1_s;
  logic                 ack2_s;
  logic                 dom_stb_s;
  logic [WORD_W-1:0]    dom_data_s;
  logic                 dom_stb_d_r;
  logic                 dom_take;

  // two flops ahead of any logic
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
    end
    else
    begin
      sync1_r <= {gen_status_i, anomaly_detector_status_i, in_ch1_ack_i, in_ch2_ack_i,
                  output_mux_channel_strobe_i, output_mux_channel_data_i};
      sync2_r <= sync1_r;
    end
  end

  assign {gen_s, sad_s, ack1_s, ack2_s, dom_stb_s, dom_data_s} = sync2_r;
  assign dom_take = dom_stb_s && !dom_stb_d_r;

  // ****************************************************************
  // output channel decode
  // ****************************************************************
  logic [NUM_WORDS-1:0] req_set;
  logic                 req_sad_set;

  assign req_set     = (dom_take && !dom_data_s[CMD_BIT]) ?
                       dom_data_s[REQ_LSB +: NUM_WORDS] : '0;
  assign req_sad_set = dom_take && !dom_data_s[CMD_BIT] && dom_data_s[REQ_SAD_BIT];

  // strobe edge, acknowledge echo and nav storage
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      dom_stb_d_r              <= 1'b0;
      output_mux_channel_ack_o <= 1'b0;
      nav_status_o             <= NAV_RST;
    end
    else
    begin
      dom_stb_d_r              <= dom_stb_s;
      output_mux_channel_ack_o <= dom_stb_s;
      if (dom_take && dom_data_s[CMD_BIT])
        nav_status_o <= dom_data_s[NAV_LSB +: NAV_W];
    end
  end

  // ****************************************************************
  // general word scanner
  // ****************************************************************
  logic [PAD_W-1:0]     gen_pad;
  logic [WORD_W-1:0]    held_r [NUM_WORDS];
  logic [NUM_WORDS-1:0] req_r;
  logic [NUM_WORDS-1:0] pend;
  logic [IDX_W-1:0]     sel;
  logic                 found;
  logic                 push;

  scm_buf_if push_if ();
  scm_buf_if pop_if ();

  // unused word bits read as zero
  assign gen_pad = {{(PAD_W-GEN_W){1'b0}}, gen_s};

  // pending words and lowest pending pick
  always_comb
  begin
    pend  = '0;
    sel   = '0;
    found = 1'b0;
    for (int k = 0; k < NUM_WORDS; k++)
    begin
      pend[k] = (gen_pad[k*WORD_W +: WORD_W] != held_r[k]) || req_r[k];
    end
    for (int k = NUM_WORDS - 1; k >= 0; k--)
    begin
      if (pend[k])
      begin
        sel   = IDX_W'(k);
        found = 1'b1;
      end
    end
  end

  assign push_if.valid = found;
  assign push_if.data  = {sel, gen_pad[sel*WORD_W +: WORD_W]};
  assign push          = push_if.valid && push_if.ready;

  // held copies follow each queued word
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      for (int k = 0; k < NUM_WORDS; k++)
        held_r[k] <= WORD_RST;
    end
    else if (push)
    begin
      held_r[sel] <= gen_pad[sel*WORD_W +: WORD_W];
    end
  end

  // request flags, a new request beats the clear
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      req_r <= REQ_RST;
    else
      req_r <= (req_r & ~(push ? (NUM_WORDS'(1) << sel) : '0)) | req_set;
  end

  scm_buf u_buf
  (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .in_if      (push_if),
    .out_if     (pop_if)
  );

  // ****************************************************************
  // channel one handshake
  // ****************************************************************
  scm_hs_t ch1_st_r;

  assign pop_if.ready = (ch1_st_r == SCM_IDLE);

  // enter high until ack, then low until ack drops
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      ch1_st_r       <= SCM_IDLE;
      in_ch1_enter_o <= 1'b0;
      in_ch1_data_o  <= WORD_RST;
      in_ch1_word_o  <= '0;
    end
    else
    begin
      unique case (ch1_st_r)
        SCM_IDLE:
        begin
          if (pop_if.valid)
          begin
            {in_ch1_word_o, in_ch1_data_o} <= pop_if.data;
            in_ch1_enter_o                 <= 1'b1;
            ch1_st_r                       <= SCM_ENTER;
          end
        end
        SCM_ENTER:
        begin
          if (ack1_s)
          begin
            in_ch1_enter_o <= 1'b0;
            ch1_st_r       <= SCM_RELEASE;
          end
        end
        SCM_RELEASE:
        begin
          if (!ack1_s)
            ch1_st_r <= SCM_IDLE;
        end
        default:
          ch1_st_r <= SCM_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // channel two, anomaly word
  // ****************************************************************
  scm_hs_t ch2_st_r;
  logic    sad_held_r;
  logic    sad_req_r;
  logic    sad_take;

  assign sad_take = (ch2_st_r == SCM_IDLE) && ((sad_s != sad_held_r) || sad_req_r);

  // request flag, set beats clear
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      sad_req_r <= 1'b0;
    else
      sad_req_r <= (sad_req_r && !sad_take) || req_sad_set;
  end

  // single-bit word with held copy
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      ch2_st_r       <= SCM_IDLE;
      sad_held_r     <= 1'b0;
      in_ch2_enter_o <= 1'b0;
      in_ch2_data_o  <= WORD_RST;
    end
    else
    begin
      unique case (ch2_st_r)
        SCM_IDLE:
        begin
          if (sad_take)
          begin
            sad_held_r     <= sad_s;
            in_ch2_data_o  <= {{(WORD_W-1){1'b0}}, sad_s};
            in_ch2_enter_o <= 1'b1;
            ch2_st_r       <= SCM_ENTER;
          end
        end
        SCM_ENTER:
        begin
          if (ack2_s)
          begin
            in_ch2_enter_o <= 1'b0;
            ch2_st_r       <= SCM_RELEASE;
          end
        end
        SCM_RELEASE:
        begin
          if (!ack2_s)
            ch2_st_r <= SCM_IDLE;
        end
        default:
          ch2_st_r <= SCM_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

// ### verif/scm_top_monitor.sv
// Purpose: port checker for scm_top
// Assumes: one clock, reset disables checks
// Notes:   bound to every scm_top instance
`timescale 1ns/1ps
`default_nettype none
module scm_top_monitor
  import scm_pkg::*;
(
  // clock and reset
  input wire logic              core_clk_i,
  input wire logic              sys_rst_i,
  // watched ports
  input wire logic [GEN_W-1:0]  gen_status_i,
  input wire logic              in_ch1_enter_o,
  input wire logic [WORD_W-1:0] in_ch1_data_o,
  input wire logic [IDX_W-1:0]  in_ch1_word_o,
  input wire logic              in_ch1_ack_i,
  input wire logic              in_ch2_enter_o,
  input wire logic [WORD_W-1:0] in_ch2_data_o,
  input wire logic              in_ch2_ack_i,
  input wire logic              output_mux_channel_strobe_i,
  input wire logic [WORD_W-1:0] output_mux_channel_data_i,
  input wire logic              output_mux_channel_ack_o,
  input wire logic [NAV_W-1:0]  nav_status_o
);
  // ****
  // checks
  // ****
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  // enter stays low while ack falls
  sequence s_quiet;
    !in_ch1_enter_o [*2];
  endsequence
  // word held unchanged
  sequence s_held;
    in_ch1_enter_o && $stable(in_ch1_data_o) && $stable(in_ch1_word_o);
  endsequence
  chk_ch1_hold: assert property (in_ch1_enter_o && !in_ch1_ack_i |=> s_held)
    else $error("channel one word not held");
  chk_ch1_release: assert property ($rose(in_ch1_ack_i) |-> ##[1:5] !in_ch1_enter_o)
    else $error("channel one enter not released");
  chk_ack_quiet: assert property ($fell(in_ch1_ack_i) |-> s_quiet)
    else $error("enter raised before ack low seen");
  chk_word_range: assert property (in_ch1_enter_o |-> in_ch1_word_o < 3'h6)
    else $error("word number out of range");
  chk_pad_zero: assert property (in_ch1_enter_o && in_ch1_word_o > 3'h2 |->
    in_ch1_data_o[11:2] == 10'h000 && (in_ch1_word_o == 3'h3 || in_ch1_data_o[1:0] == 2'h0))
    else $error("padding bits not zero");
  chk_ch2_format: assert property (in_ch2_enter_o |-> in_ch2_data_o[11:1] == 11'h000)
    else $error("anomaly word has extra bits");
  chk_ch2_hold: assert property (in_ch2_enter_o && !in_ch2_ack_i |=>
    in_ch2_enter_o && $stable(in_ch2_data_o))
    else $error("anomaly word not held");
  chk_nav_store: assert property ($rose(output_mux_channel_ack_o) && $past(output_mux_channel_data_i[11])
    |-> nav_status_o == $past(output_mux_channel_data_i[9:0]))
    else $error("navigation bits not stored");
  chk_ack_echo: assert property ($rose(output_mux_channel_strobe_i) |-> ##[2:4] output_mux_channel_ack_o)
    else $error("output word not acknowledged");
  chk_change_seen: assert property ($changed(gen_status_i) |-> ##[1:1000] in_ch1_enter_o)
    else $error("status change never sent");
endmodule
bind scm_top scm_top_monitor u_scm_top_monitor (.core_clk_i, .sys_rst_i, .gen_status_i,
  .in_ch1_enter_o, .in_ch1_data_o, .in_ch1_word_o, .in_ch1_ack_i, .in_ch2_enter_o,
  .in_ch2_data_o, .in_ch2_ack_i, .output_mux_channel_strobe_i, .output_mux_channel_data_i,
  .output_mux_channel_ack_o, .nav_status_o);
`default_nettype wire

// ### verif/scm_host_model.sv
// Purpose: computer side of one input channel
// Assumes: four-phase enter and ack
// Notes:   delay_i sets prompt or slow replies
`timescale 1ns/1ps
`default_nettype none
module scm_host_model
(
  // clock
  input  wire logic       core_clk_i,
  // channel
  input  wire logic       enter_i,
  input  wire logic [7:0] delay_i,
  output logic            ack_o
);
  // ack after delay, drop after enter falls
  initial
  begin
    ack_o = 1'b0;
    forever
    begin
      do @(posedge core_clk_i); while (enter_i !== 1'b1);
      repeat (delay_i) @(posedge core_clk_i);
      ack_o <= 1'b1;
      do @(posedge core_clk_i); while (enter_i !== 1'b0);
      repeat (delay_i) @(posedge core_clk_i);
      ack_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### verif/status_change_monitor_bench.sv
// Purpose: self-checking bench for scm_top
// Assumes: 125 MHz clock, bench drives on falling edge
// Notes:   expected words queued, a watcher pops them
`timescale 1ns/1ps
`default_nettype none
module status_change_monitor_bench;
  import scm_pkg::*;
  logic             core_clk_i = 1'b0;
  logic             sys_rst_i = 1'b1;
  logic [GEN_W-1:0] gen_status_i = '0;
  logic             anomaly_detector_status_i = 1'b0;
  logic             strobe = 1'b0;
  logic [11:0]      omc_data = 12'h000;
  logic             ack1, ack2, en1, en2, omc_ack, e1_r = 1'b0, e2_r = 1'b0;
  logic [11:0]      d1, d2;
  logic [2:0]       w1;
  logic [9:0]       nav;
  logic [7:0]       dly = 8'h01;
  logic [14:0]      q1[$];
  logic [11:0]      q2[$];
  int               errors = 0;
  int               comparisons = 0;
  // ****
  // clock, design, partners
  // ****
  always #4 core_clk_i = ~core_clk_i;
  scm_top u_scm_top (.core_clk_i, .sys_rst_i, .gen_status_i, .anomaly_detector_status_i,
    .in_ch1_enter_o(en1), .in_ch1_data_o(d1), .in_ch1_word_o(w1), .in_ch1_ack_i(ack1),
    .in_ch2_enter_o(en2), .in_ch2_data_o(d2), .in_ch2_ack_i(ack2),
    .output_mux_channel_strobe_i(strobe), .output_mux_channel_data_i(omc_data),
    .output_mux_channel_ack_o(omc_ack), .nav_status_o(nav));
  scm_host_model u_scm_host_model (.core_clk_i, .enter_i(en1), .delay_i(dly), .ack_o(ack1));
  scm_host_model u_scm_host_model_2 (.core_clk_i, .enter_i(en2), .delay_i(8'h02), .ack_o(ack2));
  // ****
  // helpers
  // ****
  task automatic check(input string what, input logic [14:0] seen, input logic [14:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [11:0] slice(input logic [GEN_W-1:0] g, input int k);
    logic [PAD_W-1:0] p;
    p = PAD_W'(g);
    return p[k*WORD_W +: WORD_W];
  endfunction
  task automatic expect1(input int k);
    q1.push_back({3'(k), slice(gen_status_i, k)});
  endtask
  task automatic drain(input string name);
    int n;
    n = 0;
    while ((q1.size() + q2.size()) > 0 && n < 3000)
    begin
      @(negedge core_clk_i);
      n++;
    end
    repeat (40) @(negedge core_clk_i);
    if (n >= 3000)
      errors++;
    $display("test %s done", name);
  endtask
  // new status lines, words that differ go out lowest first
  task automatic change(input logic [GEN_W-1:0] v);
    logic [GEN_W-1:0] old;
    old = gen_status_i;
    @(negedge core_clk_i);
    gen_status_i = v;
    for (int k = 0; k < NUM_WORDS; k++)
      if (slice(old, k) !== slice(v, k)) expect1(k);
  endtask
  // one output word, four-phase strobe
  task automatic omc(input logic [11:0] d);
    int n;
    n = 0;
    for (int k = 0; k < NUM_WORDS; k++)
      if (!d[11] && d[k]) expect1(k);
    if (!d[11] && d[6]) q2.push_back({11'h000, anomaly_detector_status_i});
    @(negedge core_clk_i);
    omc_data = d;
    strobe = 1'b1;
    while (omc_ack !== 1'b1 && n < 20)
    begin
      @(posedge core_clk_i);
      n++;
    end
    @(negedge core_clk_i);
    if (n >= 20)
      errors++;
    if (d[11]) check("nav", 15'(nav), 15'(d[9:0]));
    strobe = 1'b0;
    repeat (8) @(negedge core_clk_i);
  endtask
  // ****
  // watcher, watchdog, verdict
  // ****
  always @(negedge core_clk_i)
  begin
    e1_r <= en1;
    e2_r <= en2;
    if (en1 === 1'b1 && e1_r !== 1'b1)
      check("ch1 word", {w1, d1}, q1.size() ? q1.pop_front() : 15'h7fff);
    if (en2 === 1'b1 && e2_r !== 1'b1)
      check("ch2 word", 15'(d2), q2.size() ? 15'(q2.pop_front()) : 15'h7fff);
  end
  task automatic conclude();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    #400000;
    errors++;
    conclude();
  end
  initial
  begin
    void'($urandom(32'h6126));
    for (int k = 0; k < NUM_WORDS; k++) expect1(k);
    repeat (10) @(negedge core_clk_i);
    sys_rst_i = 1'b0;
    drain("reset");
    for (int i = 0; i < 4; i++)
    begin
      change(GEN_W'({$urandom, $urandom}));
      drain("change");
    end
    dly = 8'h14;
    change(~gen_status_i);
    drain("stall");
    dly = 8'h01;
    for (int i = 0; i < 3; i++)
    begin
      omc({5'h00, 1'b1, 6'($urandom)});
      drain("request");
    end
    for (int i = 0; i < 2; i++)
    begin
      omc({2'h2, 10'($urandom)});
      @(negedge core_clk_i);
      anomaly_detector_status_i = ~anomaly_detector_status_i;
      q2.push_back({11'h000, anomaly_detector_status_i});
      drain("anomaly");
    end
    conclude();
  end
endmodule
`default_nettype wire
